// ### hdl/chesl_pkg.sv
// Purpose: Shared constants for the card host event status logic.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses; bit positions refer to the register named in their section.

package chesl_pkg;

   // ******
   // Register offsets.
   // ******
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] intmask_offset = 8'h04;
   localparam logic [7:0] rintsts_offset = 8'h08;
   localparam logic [7:0] timeout_offset = 8'h0c;
   localparam logic [7:0] fifoth_offset = 8'h10;
   localparam logic [7:0] status_offset = 8'h14;
   localparam logic [7:0] fifodata_offset = 8'h18;

   // ******
   // Control register fields.
   // ******
   localparam int ctrl_int_enable_bit = 0;
   localparam int ctrl_boot_mode_bit = 1;
   localparam int ctrl_expect_boot_ack_bit = 2;
   localparam int ctrl_write_to_card_bit = 3;
   localparam int ctrl_width = 4;

   // ******
   // Raw status bit positions.
   // ******
   localparam int command_done_bit = 2;
   localparam int data_transfer_over_bit = 3;
   localparam int transmit_data_request_bit = 4;
   localparam int receive_data_request_bit = 5;
   localparam int data_crc_error_bit = 7;
   localparam int response_timeout_bit = 8;
   localparam int data_read_timeout_bit = 9;
   localparam int host_starvation_timeout_bit = 10;
   localparam int status_width = 11;

   // ******
   // Threshold register fields and status register fields.
   // ******
   localparam int fifoth_tx_lsb = 0;
   localparam int fifoth_rx_lsb = 16;
   localparam int level_field_lsb = 0;
   localparam int stalled_field_bit = 16;
   localparam int card_clk_field_bit = 17;

   // ******
   // Reset values.
   // ******
   localparam logic [3:0] ctrl_reset = 4'h0;
   localparam logic [10:0] intmask_reset = 11'h000;
   localparam logic [10:0] rintsts_reset = 11'h000;
   localparam logic [23:0] timeout_reset = 24'hffffff;
   localparam logic [2:0] boot_shift_reset = 3'h7;
   localparam logic [2:0] boot_ack_pattern = 3'h2;

   // ******
   // Timing.
   // ******
   localparam int clk_period_ns = 40;
   localparam int card_clk_half_ns = 160;
   localparam int card_clk_half_cycles = (card_clk_half_ns + clk_period_ns - 1) / clk_period_ns;

endpackage

// ### hdl/chesl_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: The input is asynchronous to clk.
// Notes: Only the second stage may be read by other logic.

`timescale 1ns/1ps
`default_nettype none

module chesl_sync #(
   parameter int width = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);

   logic [width-1:0] stage1;
   logic [width-1:0] next_stage1;
   logic [width-1:0] next_sync_out;

   // The first stage feeds only the second stage.
   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   // Both stages reset to one, the idle level of the card line.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= '1;
         sync_out <= '1;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end

endmodule // chesl_sync

`default_nettype wire

// ### hdl/chesl_boot_ack_detect.sv
// Purpose: Finds the boot acknowledge pattern on the card data line.
// Assumes: sample pulses once per rising card clock edge.
// Notes: The shift register refills with idle ones after a hit.

`timescale 1ns/1ps
`default_nettype none

module chesl_boot_ack_detect (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic sample,
   input wire logic dat_in,
   output logic ack_seen
);

   logic [2:0] shift;
   logic [2:0] next_shift;
   logic next_ack_seen;

   // Shift on each rising card clock edge and flag the zero-one-zero pattern.
   always_comb begin
      next_shift = shift;
      next_ack_seen = 1'b0;
      if (!enable) begin
         next_shift = chesl_pkg::boot_shift_reset;
      end else if (sample) begin
         next_shift = {shift[1:0], dat_in};
         if ({shift[1:0], dat_in} == chesl_pkg::boot_ack_pattern) begin
            next_ack_seen = 1'b1;
            next_shift = chesl_pkg::boot_shift_reset;
         end
      end
   end

   // Registers the detector state.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift <= chesl_pkg::boot_shift_reset;
         ack_seen <= 1'b0;
      end else begin
         shift <= next_shift;
         ack_seen <= next_ack_seen;
      end
   end

endmodule // chesl_boot_ack_detect

`default_nettype wire

// ### hdl/chesl_event_status.sv
// Purpose: Event status, FIFO starvation stall and interrupt for a card host controller.
// Assumes: Card-side event pulses come from logic on clk; card_dat0 is a pin.
// Notes: The FIFO is tracked by its fill level only; no data words are stored.
//
// Overview of operation
// - Stop card clock when FIFO empty on write or full on read.
// - On a stall, load the timeout counter with the programmed value and run it.
// - Set starvation timeout flag if software does not service FIFO before expiry.
// - After the timeout, keep card clock stopped and card side waiting.
// - A software push or pop restarts the card clock and card side.
// - Normal mode: bit 9 flags data read timeout and also sets transfer over.
// - Boot mode: bit 9 flags boot data begun; write one clears it.
// - Normal mode: bit 8 flags response timeout, sets command done, cancels data.
// - Boot mode with expect ack: bit 8 set on pattern 0-1-0.
// - Flag data CRC error on mismatch or negative CRC status.
// - Reading from card: request receive when level exceeds receive threshold.
// - Writing to card: request transmit when level at or below transmit threshold.
// - Status bits stay set until a one is written; zero leaves them.
// - Interrupt high only when a status bit, its mask and global enable are set.
//
// Register access over APB and the register offsets were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module chesl_event_status #(
   parameter int fifo_depth = 16,
   parameter int timeout_width = 24
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic transfer_active,
   input wire logic card_push,
   input wire logic card_pop,
   input wire logic response_timeout_event,
   input wire logic data_read_timeout_event,
   input wire logic boot_data_event,
   input wire logic data_crc_mismatch,
   input wire logic negative_crc_status,
   input wire logic card_dat0,
   output logic card_clk,
   output logic card_units_hold,
   output logic data_transfer_cancel,
   output logic irq
);

   localparam int level_width = $clog2(fifo_depth + 1);
   localparam logic [level_width-1:0] level_full = level_width'(fifo_depth);
   localparam logic [2:0] half_last = 3'(chesl_pkg::card_clk_half_cycles - 1);

   logic [chesl_pkg::ctrl_width-1:0] ctrl;
   logic [chesl_pkg::status_width-1:0] intmask;
   logic [chesl_pkg::status_width-1:0] rintsts;
   logic [timeout_width-1:0] timeout_value;
   logic [15:0] receive_watermark;
   logic [15:0] transmit_watermark;
   logic [chesl_pkg::ctrl_width-1:0] next_ctrl;
   logic [chesl_pkg::status_width-1:0] next_intmask;
   logic [chesl_pkg::status_width-1:0] next_rintsts;
   logic [timeout_width-1:0] next_timeout_value;
   logic [15:0] next_receive_watermark;
   logic [15:0] next_transmit_watermark;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic [chesl_pkg::status_width-1:0] set_bits;
   logic [chesl_pkg::status_width-1:0] clear_bits;
   logic wr_access, rd_access, addr_known, sw_push, sw_pop;
   logic [level_width-1:0] level;
   logic [level_width-1:0] next_level;
   logic stalled, stall_prev, next_stall_prev, armed, next_armed;
   logic [timeout_width-1:0] tmo_count;
   logic [timeout_width-1:0] next_tmo_count;
   logic hto_event;
   logic [2:0] div_count;
   logic [2:0] next_div_count;
   logic next_card_clk, card_clk_rise;
   logic next_card_units_hold, next_data_transfer_cancel, next_irq;
   logic dat0_sync, boot_ack_seen, boot_mode, write_dir;

   assign boot_mode = ctrl[chesl_pkg::ctrl_boot_mode_bit];
   assign write_dir = ctrl[chesl_pkg::ctrl_write_to_card_bit];

   // ******
   // Card pin synchroniser and boot acknowledge detector.
   // ******
   chesl_sync #(
      .width(1)
   ) u_dat0_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(card_dat0),
      .sync_out(dat0_sync)
   );

   chesl_boot_ack_detect u_boot_ack (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(boot_mode && ctrl[chesl_pkg::ctrl_expect_boot_ack_bit]),
      .sample(card_clk_rise),
      .dat_in(dat0_sync),
      .ack_seen(boot_ack_seen)
   );

   // ******
   // APB decode.
   // ******

   // Writes and reads take effect at the access edge only.
   always_comb begin
      wr_access = psel && penable && pready && pwrite;
      rd_access = psel && penable && pready && !pwrite;
      case (paddr)
         chesl_pkg::ctrl_offset,
         chesl_pkg::intmask_offset,
         chesl_pkg::rintsts_offset,
         chesl_pkg::timeout_offset,
         chesl_pkg::fifoth_offset,
         chesl_pkg::status_offset,
         chesl_pkg::fifodata_offset: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
      sw_push = wr_access && (paddr == chesl_pkg::fifodata_offset);
      sw_pop = rd_access && (paddr == chesl_pkg::fifodata_offset);
   end

   // Read data and the answer are prepared in the setup cycle.
   always_comb begin
      next_pready = psel && !penable;
      next_pslverr = psel && !penable && !addr_known;
      next_prdata = 32'h00000000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            chesl_pkg::ctrl_offset: next_prdata = 32'(ctrl);
            chesl_pkg::intmask_offset: next_prdata = 32'(intmask);
            chesl_pkg::rintsts_offset: next_prdata = 32'(rintsts);
            chesl_pkg::timeout_offset: next_prdata = 32'(timeout_value);
            chesl_pkg::fifoth_offset: begin
               next_prdata = {receive_watermark, transmit_watermark};
            end
            chesl_pkg::status_offset: begin
               next_prdata = 32'(level);
               next_prdata[chesl_pkg::stalled_field_bit] = stalled;
               next_prdata[chesl_pkg::card_clk_field_bit] = card_clk;
            end
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   // ******
   // Configuration registers.
   // ******

   // Software-written control, mask, timeout and threshold values.
   always_comb begin
      next_ctrl = ctrl;
      next_intmask = intmask;
      next_timeout_value = timeout_value;
      next_receive_watermark = receive_watermark;
      next_transmit_watermark = transmit_watermark;
      if (wr_access) begin
         case (paddr)
            chesl_pkg::ctrl_offset: next_ctrl = pwdata[chesl_pkg::ctrl_width-1:0];
            chesl_pkg::intmask_offset: next_intmask = pwdata[chesl_pkg::status_width-1:0];
            chesl_pkg::timeout_offset: next_timeout_value = pwdata[timeout_width-1:0];
            chesl_pkg::fifoth_offset: begin
               next_receive_watermark = pwdata[chesl_pkg::fifoth_rx_lsb +: 16];
               next_transmit_watermark = pwdata[chesl_pkg::fifoth_tx_lsb +: 16];
            end
            default: next_ctrl = ctrl;
         endcase
      end
   end

   // ******
   // FIFO level, stall and starvation timeout.
   // ******

   // Level moves with pushes and pops from both sides.
   always_comb begin
      next_level = level;
      if (write_dir) begin
         if (sw_push && !card_pop && level != level_full) begin
            next_level = level + 1'b1;
         end else if (card_pop && !sw_push && level != '0) begin
            next_level = level - 1'b1;
         end
      end else begin
         if (card_push && !sw_pop && level != level_full) begin
            next_level = level + 1'b1;
         end else if (sw_pop && !card_push && level != '0) begin
            next_level = level - 1'b1;
         end
      end
      stalled = transfer_active && (write_dir ? (level == '0) : (level == level_full));
   end

   // Counter loads on stall entry and is dropped when the stall ends.
   always_comb begin
      next_stall_prev = stalled;
      next_armed = armed;
      next_tmo_count = tmo_count;
      hto_event = 1'b0;
      if (!stalled) begin
         next_armed = 1'b0;
         next_tmo_count = '0;
      end else if (!stall_prev) begin
         next_armed = 1'b1;
         next_tmo_count = timeout_value;
      end else if (armed) begin
         if (tmo_count == '0) begin
            hto_event = 1'b1;
            next_armed = 1'b0;
         end else begin
            next_tmo_count = tmo_count - 1'b1;
         end
      end
   end

   // ******
   // Card clock divider.
   // ******

   // The divider freezes while stalled and runs again once serviced.
   always_comb begin
      next_div_count = div_count;
      next_card_clk = card_clk;
      card_clk_rise = 1'b0;
      if (!stalled) begin
         if (div_count == half_last) begin
            next_div_count = 3'h0;
            next_card_clk = !card_clk;
            card_clk_rise = !card_clk;
         end else begin
            next_div_count = div_count + 3'h1;
         end
      end
      next_card_units_hold = stalled;
   end

   // ******
   // Raw status and interrupt.
   // ******

   // Collects events; a set in the same cycle as a clear wins.
   always_comb begin
      set_bits = '0;
      set_bits[chesl_pkg::host_starvation_timeout_bit] = hto_event;
      set_bits[chesl_pkg::data_crc_error_bit] = data_crc_mismatch || negative_crc_status;
      set_bits[chesl_pkg::receive_data_request_bit] =
         transfer_active && !write_dir && (16'(level) > receive_watermark);
      set_bits[chesl_pkg::transmit_data_request_bit] =
         transfer_active && write_dir && (16'(level) <= transmit_watermark);
      next_data_transfer_cancel = 1'b0;
      if (boot_mode) begin
         set_bits[chesl_pkg::data_read_timeout_bit] = boot_data_event;
         set_bits[chesl_pkg::response_timeout_bit] = boot_ack_seen;
      end else begin
         set_bits[chesl_pkg::data_read_timeout_bit] = data_read_timeout_event;
         set_bits[chesl_pkg::data_transfer_over_bit] = data_read_timeout_event;
         set_bits[chesl_pkg::response_timeout_bit] = response_timeout_event;
         set_bits[chesl_pkg::command_done_bit] = response_timeout_event;
         next_data_transfer_cancel = response_timeout_event;
      end
      clear_bits = '0;
      if (wr_access && paddr == chesl_pkg::rintsts_offset) begin
         clear_bits = pwdata[chesl_pkg::status_width-1:0];
      end
      next_rintsts = (rintsts & ~clear_bits) | set_bits;
      next_irq = ctrl[chesl_pkg::ctrl_int_enable_bit] && |(rintsts & intmask);
   end

   // ******
   // Registers.
   // ******

   // All state of the block.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= chesl_pkg::ctrl_reset;
         intmask <= chesl_pkg::intmask_reset;
         rintsts <= chesl_pkg::rintsts_reset;
         timeout_value <= chesl_pkg::timeout_reset;
         receive_watermark <= 16'h0000;
         transmit_watermark <= 16'h0000;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         level <= '0;
         stall_prev <= 1'b0;
         armed <= 1'b0;
         tmo_count <= '0;
         div_count <= 3'h0;
         card_clk <= 1'b0;
         card_units_hold <= 1'b0;
         data_transfer_cancel <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         intmask <= next_intmask;
         rintsts <= next_rintsts;
         timeout_value <= next_timeout_value;
         receive_watermark <= next_receive_watermark;
         transmit_watermark <= next_transmit_watermark;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         level <= next_level;
         stall_prev <= next_stall_prev;
         armed <= next_armed;
         tmo_count <= next_tmo_count;
         div_count <= next_div_count;
         card_clk <= next_card_clk;
         card_units_hold <= next_card_units_hold;
         data_transfer_cancel <= next_data_transfer_cancel;
         irq <= next_irq;
      end
   end

endmodule // chesl_event_status

`default_nettype wire

// ### tb/chesl_asserts.sv
// Purpose: Port checks for the card host event status block.
// Assumes: One clock domain, clk with reset sys_rst.
// Notes: Control bits are shadowed from the APB writes the block takes.
`timescale 1ns/1ps
`default_nettype none
module chesl_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic transfer_active,
   input wire logic response_timeout_event,
   input wire logic card_clk,
   input wire logic card_units_hold,
   input wire logic data_transfer_cancel,
   input wire logic irq
);
   logic boot_q;
   logic en_q;
   logic next_boot_q;
   logic next_en_q;
   // Takes each control write at its access edge.
   always_comb begin
      next_boot_q = boot_q;
      next_en_q = en_q;
      if (psel && penable && pready && pwrite && paddr == 8'h00) begin
         next_boot_q = pwdata[1];
         next_en_q = pwdata[0];
      end
   end
   // Registers the shadow of the control bits.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         boot_q <= 1'b0;
         en_q <= 1'b0;
      end else begin
         boot_q <= next_boot_q;
         en_q <= next_en_q;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_apb_answer: assert property (psel && !penable |=> pready) else $error("pready late");
   a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   a_rto_cancel: assert property (response_timeout_event && !boot_q |=> data_transfer_cancel)
      else $error("no cancel after response timeout");
   a_cancel_cause: assert property (data_transfer_cancel |->
      $past(response_timeout_event) && !$past(boot_q)) else $error("cancel without cause");
   a_irq_enable: assert property (irq |-> $past(en_q)) else $error("irq while disabled");
   a_hold_active: assert property (card_units_hold |-> $past(transfer_active))
      else $error("hold without transfer");
   a_hold_freeze: assert property (card_units_hold && $past(card_units_hold) |->
      $stable(card_clk)) else $error("card clock moved while held");
   a_clk_high: assert property ($rose(card_clk) |-> card_clk [*4]) else $error("short high");
   a_clk_low: assert property ($fell(card_clk) |-> !card_clk [*4]) else $error("short low");
   c_irq: cover property ($rose(irq));
   c_stall: cover property ($rose(card_units_hold));
   c_cancel: cover property (data_transfer_cancel);
endmodule // chesl_asserts
`default_nettype wire

// ### tb/chesl_card_model.sv
// Purpose: Card side model that moves FIFO entries and drives the data line.
// Assumes: card_clk comes from the block in the clk domain.
// Notes: The data line idles high as if pulled up and changes on falling card clock.
`timescale 1ns/1ps
`default_nettype none
module chesl_card_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic card_clk,
   input wire logic run,
   input wire logic to_card,
   input wire logic ack_go,
   output logic card_push,
   output logic card_pop,
   output logic card_dat0
);
   logic clk_was;
   logic pend;
   logic [3:0] shift;
   // Moves one entry per rising card clock; data moves on falling ones to settle in time.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clk_was <= 1'b0;
         pend <= 1'b0;
         shift <= 4'hf;
         card_push <= 1'b0;
         card_pop <= 1'b0;
      end else begin
         clk_was <= card_clk;
         pend <= ack_go || (pend && !(clk_was && !card_clk));
         card_push <= run && !to_card && card_clk && !clk_was;
         card_pop <= run && to_card && card_clk && !clk_was;
         if (clk_was && !card_clk) begin
            shift <= pend ? 4'h5 : {shift[2:0], 1'b1};
         end
      end
   end
   assign card_dat0 = shift[3];
endmodule // chesl_card_model
`default_nettype wire

// ### tb/test_card_host_event_status_logic.sv
// Purpose: Self-checking bench for the card host event status block.
// Assumes: The card model stands on the far side of the block.
// Notes: A short data timeout keeps the stall cases brief.
`timescale 1ns/1ps
`default_nettype none
module test_card_host_event_status_logic;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} chesl_row_type;
   typedef struct {logic [3:0] c; logic [4:0] v; logic [31:0] x;} chesl_ev_type;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, k;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, card_clk, card_units_hold, data_transfer_cancel, irq;
   logic transfer_active = 1'b0, run = 1'b0, to_card = 1'b0, ack_go = 1'b0;
   logic [4:0] evs = 5'h00;
   logic card_push, card_pop, card_dat0;
   int err_total = 0, checks = 0, n;
   chesl_row_type rows [14] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h08, 0, 0, 0},
      '{0, 8'h0c, 0, 32'hffffff, 0}, '{0, 8'h1c, 0, 0, 1}, '{1, 8'h1c, 32'hff, 0, 1},
      '{1, 8'h04, 32'h7ff, 0, 0}, '{0, 8'h04, 0, 32'h7ff, 0}, '{1, 8'h0c, 32'h5, 0, 0},
      '{0, 8'h0c, 0, 32'h5, 0}, '{1, 8'h10, 32'h30002, 0, 0}, '{0, 8'h10, 0, 32'h30002, 0},
      '{1, 8'h00, 32'h1, 0, 0}, '{0, 8'h00, 0, 32'h1, 0}};
   chesl_ev_type evt [8] = '{'{4'h1, 5'h01, 32'h104}, '{4'h1, 5'h02, 32'h208},
      '{4'h1, 5'h08, 32'h80}, '{4'h1, 5'h10, 32'h80}, '{4'h1, 5'h04, 32'h0},
      '{4'h3, 5'h01, 32'h0}, '{4'h3, 5'h02, 32'h0}, '{4'h3, 5'h04, 32'h200}};
   chesl_event_status #(.fifo_depth(16), .timeout_width(24)) i_chesl_event_status (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .transfer_active(transfer_active), .card_push(card_push), .card_pop(card_pop),
      .response_timeout_event(evs[0]), .data_read_timeout_event(evs[1]),
      .boot_data_event(evs[2]), .data_crc_mismatch(evs[3]), .negative_crc_status(evs[4]),
      .card_dat0(card_dat0), .card_clk(card_clk), .card_units_hold(card_units_hold),
      .data_transfer_cancel(data_transfer_cancel), .irq(irq));
   chesl_card_model i_chesl_card_model (.clk(clk), .sys_rst(sys_rst), .card_clk(card_clk),
      .run(run), .to_card(to_card), .ack_go(ack_go), .card_push(card_push),
      .card_pop(card_pop), .card_dat0(card_dat0));
   // Makes the 25 MHz clock.
   initial forever #20 clk = ~clk;
   // Counts one comparison and reports a mismatch.
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic finish_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Ends the run when a bounded wait used up its bound.
   task automatic lim(input int n, input int m);
      if (n >= m) begin
         err_total++;
         finish_test();
      end
   endtask
   // One APB transfer; entered just after a rising edge, leaves one idle cycle.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      r = prdata;
      e = pslverr;
      lim(i, 16);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Pulses the chosen event inputs for one cycle.
   task automatic ev(input logic [4:0] v);
      evs <= v;
      @(posedge clk);
      evs <= 5'h00;
      @(posedge clk);
   endtask
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      finish_test();
   end
   // ******
   // Main sequence.
   // ******
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("pslverr", {31'h0, rows[i].e}, {31'h0, e});
         if (!rows[i].w) chk("prdata", rows[i].x, r);
      end
      foreach (evt[i]) begin
         apb(1'b1, 8'h00, {28'h0, evt[i].c});
         ev(evt[i].v);
         chk("cancel", {31'h0, evt[i].v[0] && !evt[i].c[1]}, {31'h0, data_transfer_cancel});
         apb(1'b0, 8'h08, 32'h0);
         chk("rintsts", evt[i].x, r);
         chk("irq", {31'h0, evt[i].x != 0}, {31'h0, irq});
         apb(1'b1, 8'h08, 32'h0);
         apb(1'b0, 8'h08, 32'h0);
         chk("sticky", evt[i].x, r);
         apb(1'b1, 8'h08, evt[i].x);
         apb(1'b0, 8'h08, 32'h0);
         chk("cleared", 32'h0, r);
      end
      apb(1'b1, 8'h04, 32'h004);
      ev(5'h08);
      apb(1'b0, 8'h08, 32'h0);
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h08, r);
      apb(1'b1, 8'h04, 32'h7ff);
      apb(1'b1, 8'h00, 32'h7);
      ack_go <= 1'b1;
      @(posedge clk);
      ack_go <= 1'b0;
      for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
      lim(n, 200);
      apb(1'b0, 8'h08, 32'h0);
      chk("boot ack", 32'h100, r);
      apb(1'b1, 8'h08, r);
      apb(1'b1, 8'h00, 32'h9);
      to_card <= 1'b1;
      transfer_active <= 1'b1;
      @(posedge clk);
      run <= 1'b1;
      repeat (3) @(posedge clk);
      k = card_clk;
      chk("hold", 32'h1, {31'h0, card_units_hold});
      repeat (12) @(posedge clk);
      chk("frozen", {31'h0, k}, {31'h0, card_clk});
      apb(1'b0, 8'h08, 32'h0);
      chk("starved", 32'h410, r);
      apb(1'b1, 8'h18, 32'h0);
      for (n = 0; n < 40 && card_clk === k; n++) @(posedge clk);
      lim(n, 40);
      chk("restart", 32'h1, {31'h0, card_clk !== k});
      transfer_active <= 1'b0;
      run <= 1'b0;
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h08, 32'h7ff);
      to_card <= 1'b0;
      transfer_active <= 1'b1;
      run <= 1'b1;
      for (n = 0; n < 400 && card_units_hold !== 1'b1; n++) @(posedge clk);
      lim(n, 400);
      apb(1'b0, 8'h14, 32'h0);
      chk("full", 32'h10010, r & 32'h1001f);
      apb(1'b0, 8'h08, 32'h0);
      chk("rx request", 32'h20, r & 32'h20);
      apb(1'b0, 8'h18, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk("resumed", 32'h0, r & 32'h10000);
      repeat (3) apb(1'b0, 8'h18, 32'h0);
      transfer_active <= 1'b0;
      run <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl after reset", 32'h0, r);
      apb(1'b0, 8'h0c, 32'h0);
      chk("timeout after reset", 32'hffffff, r);
      chk("irq after reset", 32'h0, {31'h0, irq});
      finish_test();
   end
endmodule // test_card_host_event_status_logic
bind chesl_event_status chesl_asserts i_chesl_asserts (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .transfer_active(transfer_active),
   .response_timeout_event(response_timeout_event), .card_clk(card_clk),
   .card_units_hold(card_units_hold), .data_transfer_cancel(data_transfer_cancel), .irq(irq));
`default_nettype wire
